// ---- bench/mdr_host_model.sv ----
// Purpose: host processor model driving the 8-bit command and data port
// Assumes: one-cycle synchronous strobes, inputs changed by non-blocking assignment at clock edges
// Notes: the data bus shows the inverse of the last byte once released, so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module mdr_host_model (
    // clock
    input wire logic core_clk,
    // device answers
    input wire logic busy_q,
    input wire logic [7:0] host_rdata_q,
    // host drives
    output logic cs_n,
    output logic port_select_n,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] host_wdata
);
    // polls that gave up waiting for busy; the bench counts them as mismatches
    int timeouts = 0;

    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        port_select_n = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        host_wdata = 8'h00;
    end

    // one raw access; no busy check, so refusal scenarios can use it directly
    task automatic pulse(input logic sel, input logic wr, input logic rd, input logic [7:0] data);
        @(posedge core_clk);
        cs_n <= 1'b0;
        port_select_n <= sel;
        wr_stb <= wr;
        rd_stb <= rd;
        host_wdata <= data;
        @(posedge core_clk);
        cs_n <= 1'b1;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        host_wdata <= ~data;
    endtask : pulse

    // command write, then one edge so busy has risen before anyone polls it
    task automatic cmd(input logic [7:0] code);
        pulse(1'b0, 1'b1, 1'b0, code);
        @(posedge core_clk);
    endtask : cmd

    // polled read: busy is checked at an edge before every byte
    task automatic rd(input logic sel, output logic [7:0] b);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (busy_q !== 1'b0 && n < 100);
        if (busy_q !== 1'b0) timeouts++;
        pulse(sel, 1'b0, 1'b1, 8'h00);
        #1 b = host_rdata_q;
    endtask : rd
endmodule : mdr_host_model
`default_nettype wire

// ---- bench/motion_data_readback_tb.sv ----
// Purpose: self-checking bench for the readback command port
// Assumes: phase B leading phase A counts up; status bits 6..4, 2, 1 mirror event flags 5..3, 1, 0; bit 3 latches flag 2 and index
// Notes: ordinary readbacks are table rows; refusals, abort, encoder and index are hand tests
`timescale 1ns/100ps
`default_nettype none
module motion_data_readback_tb;
    import mdr_pkg::*;
    typedef struct {logic [7:0] code; int n; logic [31:0] exp;} mdr_row_t;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cs_n, port_select_n, wr_stb, rd_stb, busy_q;
    logic [7:0] host_wdata, host_rdata_q, b;
    logic phase_a = 1'b0, phase_b = 1'b0, index_n = 1'b1;
    logic [31:0] desired_pos = 32'h12345678, desired_vel = 32'hFFFE8000, actual_pos_q, v;
    logic [15:0] actual_vel = 16'hFF80, integral_sum = 16'h0123;
    logic [5:0] event_flags = 6'h00;
    int err_total = 0, samples_checked = 0;
    mdr_row_t rows[5] = '{'{CMD_RD_DES_VEL, 4, 32'hFFFE8000}, '{CMD_RD_DES_POS, 4, 32'h12345678},
        '{CMD_RD_ACT_VEL, 2, 32'h0000FF80}, '{CMD_RD_INT_SUM, 2, 32'h00000123},
        '{CMD_RD_ACT_POS, 4, 32'h00000000}};

    mdr_readback dut (.core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n),
        .port_select_n(port_select_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .host_wdata(host_wdata), .host_rdata_q(host_rdata_q), .phase_a(phase_a),
        .phase_b(phase_b), .index_n(index_n), .desired_pos(desired_pos),
        .desired_vel(desired_vel), .actual_vel(actual_vel), .integral_sum(integral_sum),
        .event_flags(event_flags), .busy_q(busy_q), .actual_pos_q(actual_pos_q));
    mdr_host_model host (.core_clk(core_clk), .busy_q(busy_q), .host_rdata_q(host_rdata_q),
        .cs_n(cs_n), .port_select_n(port_select_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .host_wdata(host_wdata));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // one comparison, counted; mismatch reported at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // gather n bytes, most significant first
    task automatic rdn(input int n, output logic [31:0] r);
        r = 32'h0;
        for (int i = 0; i < n; i++) begin
            host.rd(1'b1, b);
            r = {r[23:0], b};
        end
    endtask : rdn

    // one forward quadrature cycle, each phase held one clock: no filter to wait out
    task automatic fwd_cycle();
        logic [1:0] seq[4] = '{2'b01, 2'b11, 2'b10, 2'b00};
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {phase_a, phase_b} <= seq[i];
        end
        repeat (3) @(posedge core_clk);
    endtask : fwd_cycle

    task automatic conclude();
        err_total += host.timeouts;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // hang guard, well past the expected run length
    initial begin
        #200000;
        err_total++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1 check({23'h0, busy_q, host_rdata_q}, 32'h0);
        check(actual_pos_q, 32'h0);
        // table of plain readbacks
        foreach (rows[i]) begin
            host.cmd(rows[i].code);
            rdn(rows[i].n, v);
            check(v, rows[i].exp);
        end
        $display("test table done");
        // command written while busy is ignored; raw pulses so the second lands in busy
        host.pulse(1'b0, 1'b1, 1'b0, CMD_RD_ACT_VEL);
        host.pulse(1'b0, 1'b1, 1'b0, CMD_RD_DES_POS);
        rdn(2, v);
        check(v, 32'h0000FF80);
        check({v[15:0], 16'h0000}, 32'hFF800000);
        // data read while busy leaves the port buffer alone
        host.pulse(1'b0, 1'b1, 1'b0, CMD_RD_INT_SUM);
        host.pulse(1'b1, 1'b0, 1'b1, 8'h00);
        #1 check({24'h0, host_rdata_q}, 32'h00000080);
        rdn(2, v);
        check(v, 32'h00000123);
        $display("test busy refusal done");
        // new command in mid-sequence aborts the old one
        host.cmd(CMD_RD_ACT_POS);
        host.rd(1'b1, b);
        host.cmd(CMD_RD_DES_POS);
        rdn(4, v);
        check(v, 32'h12345678);
        $display("test abort done");
        // encoder motion with a glitch that returns, read during motion
        fwd_cycle();
        check(actual_pos_q, 32'h4);
        @(posedge core_clk);
        phase_a <= 1'b1;
        @(posedge core_clk);
        phase_a <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(actual_pos_q, 32'h4);
        host.cmd(CMD_RD_ACT_POS);
        fork
            fwd_cycle();
            rdn(4, v);
        join
        check({2'b00, v[31:2]}, 32'h1);
        check(actual_pos_q, 32'h8);
        $display("test encoder done");
        // arm, index pulse at 8, move on, then read capture and status
        host.cmd(CMD_ARM_INDEX);
        repeat (5) @(posedge core_clk);
        index_n <= 1'b0;
        @(posedge core_clk);
        index_n <= 1'b1;
        fwd_cycle();
        host.cmd(CMD_RD_INDEX);
        rdn(4, v);
        check(v, 32'h8);
        @(posedge core_clk);
        event_flags <= 6'b110010;
        host.rd(1'b0, b);
        check({28'h0, b[6:4], b[2]}, 32'hD);
        check({31'h0, b[STAT_INDEX_BIT]}, 32'h1);
        $display("test index and status done");
        // out-of-window setpoint reads back clamped to the window edge
        @(posedge core_clk);
        desired_pos <= 32'h7FFFFFFF;
        host.cmd(CMD_RD_DES_POS);
        rdn(4, v);
        check(v, 32'h3FFFFFFF);
        // mid-run reset: outputs cleared, first command after release served
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1 check({23'h0, busy_q, host_rdata_q}, 32'h0);
        check(actual_pos_q, 32'h0);
        host.cmd(CMD_RD_ACT_VEL);
        rdn(2, v);
        check(v, 32'h0000FF80);
        $display("test clamp and reset done");
        conclude();
    end
endmodule : motion_data_readback_tb
`default_nettype wire

// ---- logic/mdr_pkg.sv ----
// Purpose: constants for the motion data readback block
// Assumes: 100 MHz core clock, host port sampled synchronously
// Notes: command codes, byte counts, status layout and position window
// Function
// - index read returns captured index, four bytes
// - index register loads on index after arming
// - code 08 returns desired position, MSB first
// - code 0A returns actual position, MSB first
// - positions clamp to C0000000..3FFFFFFF window
// - code 07 returns desired velocity, four bytes
// - desired velocity readback is signed
// - code 0B returns signed integer actual velocity
// - code 0D returns two-byte integral sum
// - host reads status after interrupt asserts
// - new command aborts incomplete earlier command
// - status byte shows all conditions unmasked
// - eight-bit bus, chip select, port select
// - encoder takes A, B, index lines
// - decoder rejects non-persistent phase noise
// - decoder has no digital noise filter
// - busy ignores writes, reads give stale buffer; here status reads still load status_q while busy
package mdr_pkg;
    localparam logic [7:0] CMD_RD_DES_VEL = 8'h07;
    localparam logic [7:0] CMD_RD_DES_POS = 8'h08;
    localparam logic [7:0] CMD_RD_INDEX = 8'h09;
    localparam logic [7:0] CMD_RD_ACT_POS = 8'h0A;
    localparam logic [7:0] CMD_RD_ACT_VEL = 8'h0B;
    localparam logic [7:0] CMD_RD_INT_SUM = 8'h0D;
    localparam logic [7:0] CMD_ARM_INDEX = 8'h03;
    localparam logic [2:0] BYTES_FOUR = 3'h4;
    localparam logic [2:0] BYTES_TWO = 3'h2;
    localparam logic [31:0] POS_MIN = 32'hC0000000;
    localparam logic [31:0] POS_MAX = 32'h3FFFFFFF;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CMD_ERR_BIT = 1;
    localparam int STAT_INDEX_BIT = 3;
    localparam logic [1:0] BUSY_CYCLES = 2'h2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    typedef enum logic [2:0] {
        MDR_IDLE = 3'b001,
        MDR_BUSY = 3'b010,
        MDR_SEND = 3'b100
    } mdr_state_t;
endpackage : mdr_pkg

// ---- logic/mdr_quad_dec.sv ----
// Purpose: quadrature decoder with index capture
// Assumes: encoder lines synchronous to core_clk
// Notes: no filter, glitches that return cancel out
`timescale 1ns/100ps
`default_nettype none
module mdr_quad_dec (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // encoder lines
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic index_n,
    // control
    input wire logic arm_index,
    // results
    output logic [31:0] position_q,
    output logic [31:0] index_pos_q,
    output logic index_armed_q,
    output logic index_seen_q
);
    import mdr_pkg::*;
    logic [1:0] ab_q;
    logic signed [1:0] step;
    // gray step decode: a glitch that returns undoes its own count
    always_comb begin
        case ({ab_q, phase_a, phase_b})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: step = 2'sb01;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: step = -2'sb01;
            default: step = 2'sb00;
        endcase
    end
    // raw lines used directly for full decode bandwidth
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ab_q <= 2'h0;
        end else begin
            ab_q <= {phase_a, phase_b};
        end
    end
    // position count, held in the window
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            position_q <= 32'h0;
        end else if (step == 2'sb01 && position_q != POS_MAX) begin
            position_q <= position_q + 32'h1;
        end else if (step == -2'sb01 && position_q != POS_MIN) begin
            position_q <= position_q - 32'h1;
        end
    end
    // index capture once per arming; index tied high never captures
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            index_pos_q <= 32'h0;
            index_armed_q <= 1'b0;
            index_seen_q <= 1'b0;
        end else begin
            index_seen_q <= 1'b0;
            if (arm_index) begin
                index_armed_q <= 1'b1;
            end else if (index_armed_q && !index_n) begin
                index_pos_q <= position_q;
                index_armed_q <= 1'b0;
                index_seen_q <= 1'b1;
            end
        end
    end
    index_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !$past(index_seen_q) && !index_seen_q |-> $stable(index_pos_q))
        else $error("index position changed without capture");
endmodule : mdr_quad_dec
`default_nettype wire

// ---- logic/mdr_readback.sv ----
// Purpose: host command port serving data readback commands
// Assumes: host strobes are one-cycle synchronous pulses
// Notes: motion values arrive as ports; reads never disturb them
`timescale 1ns/100ps
`default_nettype none
module mdr_readback #(
    parameter int POS_W = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // host port
    input wire logic cs_n,
    input wire logic port_select_n,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_q,
    // encoder
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic index_n,
    // motion sources
    input wire logic [POS_W-1:0] desired_pos,
    input wire logic [31:0] desired_vel,
    input wire logic [15:0] actual_vel,
    input wire logic [15:0] integral_sum,
    input wire logic [5:0] event_flags,
    // status
    output logic busy_q,
    output logic [31:0] actual_pos_q
);
    import mdr_pkg::*;
    mdr_state_t state_q;
    logic [31:0] shift_q;
    logic [2:0] left_q;
    logic [1:0] busy_cnt_q;
    logic [7:0] status_q;
    logic [7:0] cmd_q;
    logic [31:0] pos_w;
    logic [31:0] index_w;
    logic armed_w;
    logic seen_w;
    logic cmd_wr;
    logic data_rd;
    logic status_rd;
    logic is_read_cmd;

    mdr_quad_dec u_dec (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .phase_a(phase_a),
        .phase_b(phase_b),
        .index_n(index_n),
        .arm_index(cmd_wr && !busy_q && host_wdata == CMD_ARM_INDEX),
        .position_q(pos_w),
        .index_pos_q(index_w),
        .index_armed_q(armed_w),
        .index_seen_q(seen_w)
    );

    // port decode: select low means command/status port
    assign cmd_wr = !cs_n && wr_stb && !port_select_n;
    assign data_rd = !cs_n && rd_stb && port_select_n;
    assign status_rd = !cs_n && rd_stb && !port_select_n;

    // clamp into the documented position window
    function automatic logic [31:0] clamp_pos(input logic [31:0] v);
        if ($signed(v) > $signed(POS_MAX)) begin
            clamp_pos = POS_MAX;
        end else if ($signed(v) < $signed(POS_MIN)) begin
            clamp_pos = POS_MIN;
        end else begin
            clamp_pos = v;
        end
    endfunction : clamp_pos

    assign is_read_cmd = (host_wdata inside {CMD_RD_DES_VEL, CMD_RD_DES_POS, CMD_RD_INDEX,
        CMD_RD_ACT_POS, CMD_RD_ACT_VEL, CMD_RD_INT_SUM});

    // command sequencer; a new command accepted while not busy restarts, aborting leftovers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= MDR_IDLE;
            cmd_q <= 8'h00;
            busy_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                MDR_IDLE, MDR_SEND: begin
                    if (cmd_wr && !busy_q) begin
                        cmd_q <= host_wdata;
                        busy_cnt_q <= BUSY_CYCLES;
                        state_q <= is_read_cmd ? MDR_BUSY : MDR_IDLE;
                    end else if (state_q == MDR_SEND && left_q == 3'h0) begin
                        state_q <= MDR_IDLE;
                    end
                end
                MDR_BUSY: begin
                    busy_cnt_q <= busy_cnt_q - 2'h1;
                    if (busy_cnt_q == 2'h1) begin
                        state_q <= MDR_SEND;
                    end
                end
                default: state_q <= MDR_IDLE;
            endcase
        end
    end

    // busy flag shadows the fetch phase; writes then are ignored
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q == MDR_BUSY && busy_cnt_q != 2'h1)
                || (cmd_wr && !busy_q && is_read_cmd);
        end
    end

    // snapshot value at fetch end so bytes belong to one sample
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= 32'h0;
            left_q <= 3'h0;
        end else if (cmd_wr && !busy_q) begin
            left_q <= 3'h0;
        end else if (state_q == MDR_BUSY && busy_cnt_q == 2'h1) begin
            case (cmd_q)
                CMD_RD_INDEX: begin
                    shift_q <= clamp_pos(index_w);
                    left_q <= BYTES_FOUR;
                end
                CMD_RD_DES_POS: begin
                    shift_q <= clamp_pos(desired_pos);
                    left_q <= BYTES_FOUR;
                end
                CMD_RD_ACT_POS: begin
                    shift_q <= clamp_pos(pos_w);
                    left_q <= BYTES_FOUR;
                end
                CMD_RD_DES_VEL: begin
                    shift_q <= desired_vel;
                    left_q <= BYTES_FOUR;
                end
                CMD_RD_ACT_VEL: begin
                    shift_q <= {actual_vel, 16'h0000};
                    left_q <= BYTES_TWO;
                end
                CMD_RD_INT_SUM: begin
                    shift_q <= {integral_sum, 16'h0000};
                    left_q <= BYTES_TWO;
                end
                default: left_q <= 3'h0;
            endcase
        end else if (data_rd && !busy_q && state_q == MDR_SEND && left_q != 3'h0) begin
            shift_q <= {shift_q[23:0], 8'h00};
            left_q <= left_q - 3'h1;
        end
    end

    // read buffer: busy data reads return what the buffer already holds; status reads load status_q even when busy
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_rdata_q <= 8'h00;
        end else if (status_rd) begin
            host_rdata_q <= status_q;
        end else if (data_rd && !busy_q && state_q == MDR_SEND && left_q != 3'h0) begin
            host_rdata_q <= shift_q[31:24];
        end
    end

    // status: raw conditions, never masked; index bit stays set until reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q[7:4] <= {1'b0, event_flags[5:3]};
            status_q[2] <= event_flags[1];
            status_q[STAT_INDEX_BIT] <= status_q[STAT_INDEX_BIT] | seen_w | event_flags[2];
            // a read with nothing left to send is an error, even before send ends
            status_q[STAT_CMD_ERR_BIT] <= event_flags[0]
                | (data_rd && !busy_q && (state_q != MDR_SEND || left_q == 3'h0));
            status_q[STAT_BUSY_BIT] <= busy_q;
        end
    end

    // actual position out for the loop
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            actual_pos_q <= 32'h0;
        end else begin
            actual_pos_q <= clamp_pos(pos_w);
        end
    end

    sequence fetch_s;
        cmd_wr && !busy_q && is_read_cmd;
    endsequence
    cmd_busy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        fetch_s |=> busy_q)
        else $error("busy not raised after read command");
    busy_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        fetch_s |-> ##[1:3] !busy_q)
        else $error("busy held too long");
    abort_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        cmd_wr && !busy_q |=> left_q == 3'h0)
        else $error("old bytes survived new command");
    window_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $signed(actual_pos_q) <= $signed(POS_MAX)
        && $signed(actual_pos_q) >= $signed(POS_MIN))
        else $error("position outside window");
    sequence arm_s;
        cmd_wr && !busy_q && host_wdata == CMD_ARM_INDEX;
    endsequence
    index_arm_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        arm_s |=> armed_w)
        else $error("index capture not armed by command");
    stale_rd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        data_rd && busy_q |=> $stable(host_rdata_q))
        else $error("busy read changed buffer");
    byte_order_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        data_rd && !busy_q && state_q == MDR_SEND && left_q != 3'h0 && !status_rd
        |=> host_rdata_q == $past(shift_q[31:24]))
        else $error("byte not most significant first");
    status_raw_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        event_flags[3] |=> status_q[4])
        else $error("status missed a condition");
    vel_count_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == MDR_BUSY && busy_cnt_q == 2'h1 && cmd_q == CMD_RD_ACT_VEL
        |=> left_q == BYTES_TWO)
        else $error("velocity byte count wrong");
endmodule : mdr_readback
`default_nettype wire
